/* hw/qdt_chan.sv */
// One converter channel: input register, output register, mode and termination selects.
// Assumes commit strobes arrive as single-cycle pulses from the serial engine.
`timescale 1ns/1ps
module qdt_chan #(
  parameter int RES = 12
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Commit strobes
  input  wire logic           wr_sel,
  input  wire logic           clear,
  input  wire logic           update,
  input  wire logic [RES-1:0] wr_code,
  input  wire logic [1:0]     wr_mode,
  // Channel state
  output logic      [RES-1:0] in_code_q,
  output logic      [RES-1:0] out_code_q,
  output logic      [1:0]     mode_q,
  output logic                amp_en_q,
  output logic                term_1k_q,
  output logic                term_100k_q
);

  logic           dirty_q;
  wire  logic     wr_go    = wr_sel & ~clear;
  wire  logic     dirty_nx = dirty_q | wr_go;
  wire  logic     load_out = update & dirty_nx;
  wire  logic [RES-1:0] in_d = clear ? '0 : (wr_go ? wr_code : in_code_q);

  // ************************************************************
  // Registers
  // ************************************************************
  // Mode changes never touch the output code, so leaving power-down restores it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_code_q  <= '0;
      out_code_q <= '0;
      dirty_q    <= 1'h0;
      mode_q     <= qdt_pkg::MODE_NORMAL;
    end else begin
      in_code_q  <= in_d;
      dirty_q    <= (clear | load_out) ? 1'h0 : dirty_nx;
      out_code_q <= clear ? '0 : (load_out ? in_d : out_code_q);
      mode_q     <= wr_sel ? wr_mode : mode_q;
    end
  end

  // The termination selects are registered so the pins never glitch on a mode write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_en_q    <= 1'h1;
      term_1k_q   <= 1'h0;
      term_100k_q <= 1'h0;
    end else begin
      amp_en_q    <= (mode_q == qdt_pkg::MODE_NORMAL);
      term_1k_q   <= (mode_q == qdt_pkg::MODE_PD_1K);
      term_100k_q <= (mode_q == qdt_pkg::MODE_PD_100K);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_pd_select: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q != qdt_pkg::MODE_NORMAL) |=> !amp_en_q
      && (term_1k_q == ($past(mode_q) == qdt_pkg::MODE_PD_1K))
      && (term_100k_q == ($past(mode_q) == qdt_pkg::MODE_PD_100K)))
    else $error("power-down select does not follow mode");

  a_pd_keeps_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_sel && !clear && !update && wr_mode != qdt_pkg::MODE_NORMAL) |=> $stable(out_code_q))
    else $error("entering power-down changed the output code");

  a_clean_skip: assert property (
    @(posedge clk) disable iff (!rst_n)
    (update && !dirty_q && !wr_sel && !clear) |=> $stable(out_code_q))
    else $error("output reloaded without a new input code");

  a_dirty_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (update && dirty_q && !wr_sel && !clear) |=> (out_code_q == in_code_q) && !dirty_q)
    else $error("pending input code not moved to output");

endmodule // qdt_chan

/* hw/qdt_pkg.sv */
// Shared constants for the quad converter two-wire control block.
// Assumes nothing beyond a SystemVerilog compiler; holds no logic.
package qdt_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          NUM_CH       = 4;
  localparam int          WORD_W       = 16;
  localparam int          FIELD_W      = 12;
  localparam logic [3:0]  BIT_LAST     = 4'h8;

  // ************************************************************
  // Slave address and direction bit
  // ************************************************************
  localparam logic [5:0]  SLAVE_PREFIX = 6'h06;
  localparam logic        DIR_WRITE    = 1'h0;
  localparam logic        DIR_READ     = 1'h1;

  // ************************************************************
  // Data word field positions
  // ************************************************************
  localparam int          MODE_HI_BIT  = 15;
  localparam int          MODE_LO_BIT  = 14;
  localparam int          CLEAR_BIT    = 13;
  localparam int          HOLD_BIT     = 12;
  localparam int          DATA_MSB     = 11;

  // ************************************************************
  // Operating modes and reset values
  // ************************************************************
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_PD_1K   = 2'h1;
  localparam logic [1:0]  MODE_PD_100K = 2'h2;
  localparam logic [1:0]  MODE_PD_HIZ  = 2'h3;
  localparam logic [3:0]  PTR_RESET    = 4'h0;
  localparam logic [15:0] RB_DEFAULT   = 16'h2000;
  localparam logic [1:0]  RB_CTL_BITS  = 2'h2;

  // ************************************************************
  // Serial engine states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } qdt_state_e;

endpackage

/* hw/qdt_twi.sv */
// Two-wire slave control for a quad converter: serial engine, pointer and channel banks.
// Assumes scl_in and sda_in come from pins; sda_oe pulls the open-drain line low.
//
// Overview of operation
// - Address byte with write bit 0 opens a write; device acknowledges it.
// - Pointer byte follows the address in a write and is acknowledged.
// - Repeated start with read bit 1 is acknowledged; transmit follows.
// - Read returns two bytes of the selected channel register.
// - Master acknowledge after second byte repeats the same byte pair.
// - Read without pointer byte reuses the stored pointer.
// - Readback uses write layout; don't-care positions read as zero.
// - Input registers load only after a complete valid write.
// - Hold bit 1 keeps output registers; input registers take the code.
// - Hold bit 0 copies input to output registers at write completion.
// - Simultaneous update reloads only channels written since their last update.
// - Bits 15 and 14 select the mode of addressed channels.
// - Modes: normal, 1k pull-down, 100k pull-down, three-state.
// - Power-down disconnects the amplifier and selects the termination.
// - Power-down leaves output register contents intact.
// - Device answers only to the address set by its select pin.
// - Address is fixed six-bit prefix plus select pin level.
// - Word: mode bits, clear bit 13, hold bit 12, left-justified data.
// - Clear bit 0 zeroes all input and output registers.
// - Each pointer bit selects a channel; several take the same word.
`timescale 1ns/1ps
module qdt_twi #(
  parameter int RES = 12
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Two-wire bus
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  // Strap
  input  wire logic                          addr_select_pin,
  // Channel outputs
  output logic [qdt_pkg::NUM_CH*RES-1:0]     dac_code,
  output logic [qdt_pkg::NUM_CH-1:0]         powerdown_sel_hi,
  output logic [qdt_pkg::NUM_CH-1:0]         powerdown_sel_lo,
  output logic [qdt_pkg::NUM_CH-1:0]         amp_en,
  output logic [qdt_pkg::NUM_CH-1:0]         term_1k_en,
  output logic [qdt_pkg::NUM_CH-1:0]         term_100k_en
);

  localparam int PAD = qdt_pkg::FIELD_W - RES;

  if (!(RES == 8 || RES == 10 || RES == 12)) begin : g_bad_res
    $error("qdt_twi: RES must be 8, 10 or 12");
  end

  // ************************************************************
  // Reset and input synchronisers
  // ************************************************************
  logic rst_m_q;
  logic rst_n_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_m_q <= 1'h1;
      rst_n_q <= rst_m_q;
    end
  end

  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic asel_m_q;
  logic asel_s_q;

  // Bus lines idle high, so the clock and data synchronisers reset high to avoid a false start.
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_m_q  <= 1'h1;
      scl_s_q  <= 1'h1;
      scl_p_q  <= 1'h1;
      sda_m_q  <= 1'h1;
      sda_s_q  <= 1'h1;
      sda_p_q  <= 1'h1;
      asel_m_q <= 1'h0;
      asel_s_q <= 1'h0;
    end else begin
      scl_m_q  <= scl_in;
      scl_s_q  <= scl_m_q;
      scl_p_q  <= scl_s_q;
      sda_m_q  <= sda_in;
      sda_s_q  <= sda_m_q;
      sda_p_q  <= sda_s_q;
      asel_m_q <= addr_select_pin;
      asel_s_q <= asel_m_q;
    end
  end

  wire logic start_seen = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire logic stop_seen  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire logic scl_rise   = scl_s_q & ~scl_p_q;
  wire logic scl_fall   = ~scl_s_q & scl_p_q;

  // ************************************************************
  // Serial engine state
  // ************************************************************
  qdt_pkg::qdt_state_e state_q, state_d;
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [7:0]  shift_q, shift_d;
  logic        ack_ph_q, ack_ph_d;
  logic        sda_oe_d;
  logic [3:0]  ptr_q, ptr_d;
  logic [7:0]  hi_q, hi_d;
  logic [7:0]  lo_q, lo_d;
  logic        wbyte_q, wbyte_d;
  logic        rbyte_q, rbyte_d;
  logic        pend_q, pend_d;

  wire logic [6:0] my_addr    = {qdt_pkg::SLAVE_PREFIX, asel_s_q};
  wire logic       addr_match = (shift_q[7:1] == my_addr);
  wire logic       byte_done  = scl_fall & ~ack_ph_q & (bit_cnt_q == qdt_pkg::BIT_LAST);
  wire logic       in_read    = (state_q == qdt_pkg::ST_RDATA);

  // ************************************************************
  // Readback word
  // ************************************************************
  logic [qdt_pkg::NUM_CH*RES-1:0] in_codes;
  logic [qdt_pkg::NUM_CH*2-1:0]   modes;
  logic [15:0]                    rb_acc [qdt_pkg::NUM_CH+1];

  assign rb_acc[0] = '0;
  for (genvar i = 0; i < qdt_pkg::NUM_CH; i++) begin : g_rb
    wire logic [11:0] field = 12'(in_codes[i*RES +: RES]) << PAD;
    wire logic [15:0] word  = {modes[2*i +: 2], qdt_pkg::RB_CTL_BITS, field};
    assign rb_acc[i+1] = rb_acc[i] | (ptr_q[i] ? word : 16'h0000);
  end

  // No channel or several channels selected reads the power-on pattern.
  wire logic [15:0] rb_word = $onehot(ptr_q) ? rb_acc[qdt_pkg::NUM_CH] : qdt_pkg::RB_DEFAULT;
  wire logic [7:0]  tx_byte = rbyte_q ? rb_word[7:0] : rb_word[15:8];
  wire logic [2:0]  tx_idx  = 3'h7 - bit_cnt_q[2:0];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    ack_ph_d  = ack_ph_q;
    sda_oe_d  = sda_oe;
    ptr_d     = ptr_q;
    hi_d      = hi_q;
    lo_d      = lo_q;
    wbyte_d   = wbyte_q;
    rbyte_d   = rbyte_q;
    pend_d    = pend_q;
    if (stop_seen || start_seen) begin
      state_d   = stop_seen ? qdt_pkg::ST_IDLE : qdt_pkg::ST_ADDR;
      bit_cnt_d = 4'h0;
      ack_ph_d  = 1'h0;
      sda_oe_d  = 1'h0;
      pend_d    = 1'h0;
    end else if (scl_rise) begin
      if (!ack_ph_q && bit_cnt_q != qdt_pkg::BIT_LAST) begin
        shift_d   = {shift_q[6:0], sda_s_q};
        bit_cnt_d = bit_cnt_q + 4'h1;
      end else if (ack_ph_q && in_read && sda_s_q) begin
        state_d = qdt_pkg::ST_IGNORE;
      end
    end else if (byte_done) begin
      ack_ph_d  = 1'h1;
      bit_cnt_d = 4'h0;
      sda_oe_d  = 1'h0;
      case (state_q)
        qdt_pkg::ST_ADDR: begin
          if (addr_match) begin
            sda_oe_d = 1'h1;
            rbyte_d  = 1'h0;
            state_d  = (shift_q[0] == qdt_pkg::DIR_READ) ? qdt_pkg::ST_RDATA
                                                        : qdt_pkg::ST_PTR;
          end else begin
            state_d = qdt_pkg::ST_IGNORE;
          end
        end
        qdt_pkg::ST_PTR: begin
          sda_oe_d = 1'h1;
          ptr_d    = shift_q[3:0];
          wbyte_d  = 1'h0;
          state_d  = qdt_pkg::ST_WDATA;
        end
        qdt_pkg::ST_WDATA: begin
          sda_oe_d = 1'h1;
          wbyte_d  = ~wbyte_q;
          if (!wbyte_q) begin
            hi_d = shift_q;
          end else begin
            lo_d   = shift_q;
            pend_d = 1'h1;
          end
        end
        qdt_pkg::ST_RDATA: begin
          rbyte_d = ~rbyte_q;
        end
        default: begin
          sda_oe_d = 1'h0;
        end
      endcase
    end else if (scl_fall && ack_ph_q) begin
      ack_ph_d = 1'h0;
      sda_oe_d = in_read & ~tx_byte[7];
    end else if (scl_fall && in_read) begin
      sda_oe_d = ~tx_byte[tx_idx];
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q   <= qdt_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ack_ph_q  <= 1'h0;
      sda_oe    <= 1'h0;
      sda_out   <= 1'h0;
      ptr_q     <= qdt_pkg::PTR_RESET;
      hi_q      <= 8'h00;
      lo_q      <= 8'h00;
      wbyte_q   <= 1'h0;
      rbyte_q   <= 1'h0;
      pend_q    <= 1'h0;
    end else begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      ack_ph_q  <= ack_ph_d;
      sda_oe    <= sda_oe_d;
      sda_out   <= 1'h0;
      ptr_q     <= ptr_d;
      hi_q      <= hi_d;
      lo_q      <= lo_d;
      wbyte_q   <= wbyte_d;
      rbyte_q   <= rbyte_d;
      pend_q    <= pend_d;
    end
  end

  // ************************************************************
  // Commit and channel banks
  // ************************************************************
  // The word is applied when the write ends, so a cut-short write leaves the channel registers untouched.
  wire logic [15:0]    cw      = {hi_q, lo_q};
  wire logic           commit  = (stop_seen | start_seen) & pend_q;
  wire logic           clr_go  = commit & ~cw[qdt_pkg::CLEAR_BIT];
  wire logic           upd_go  = commit & cw[qdt_pkg::CLEAR_BIT] & ~cw[qdt_pkg::HOLD_BIT];
  wire logic [RES-1:0] wr_code = cw[qdt_pkg::DATA_MSB -: RES];
  wire logic [1:0]     wr_mode = cw[qdt_pkg::MODE_HI_BIT:qdt_pkg::MODE_LO_BIT];

  for (genvar i = 0; i < qdt_pkg::NUM_CH; i++) begin : g_ch
    logic [1:0] mode_i;
    qdt_chan #(
      .RES (RES)
    ) u_chan (
      .clk         (mclk),
      .rst_n       (rst_n_q),
      .wr_sel      (commit & ptr_q[i]),
      .clear       (clr_go),
      .update      (upd_go),
      .wr_code     (wr_code),
      .wr_mode     (wr_mode),
      .in_code_q   (in_codes[i*RES +: RES]),
      .out_code_q  (dac_code[i*RES +: RES]),
      .mode_q      (mode_i),
      .amp_en_q    (amp_en[i]),
      .term_1k_q   (term_1k_en[i]),
      .term_100k_q (term_100k_en[i])
    );
    assign modes[2*i +: 2]     = mode_i;
    assign powerdown_sel_hi[i] = mode_i[1];
    assign powerdown_sel_lo[i] = mode_i[0];
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_addr_byte;
    byte_done && state_q == qdt_pkg::ST_ADDR;
  endsequence

  sequence s_write_end;
    (stop_seen || start_seen) && pend_q;
  endsequence

  a_addr_ack: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    s_addr_byte and addr_match |=> sda_oe && ack_ph_q
      && (state_q == ($past(shift_q[0]) ? qdt_pkg::ST_RDATA : qdt_pkg::ST_PTR)))
    else $error("matching address not acknowledged");

  a_addr_miss: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    s_addr_byte and !addr_match |=> !sda_oe && state_q == qdt_pkg::ST_IGNORE)
    else $error("foreign address acknowledged");

  a_ptr_ack: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    byte_done && state_q == qdt_pkg::ST_PTR |=> sda_oe && ptr_q == $past(shift_q[3:0]))
    else $error("pointer byte not acknowledged or not stored");

  a_read_nack: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    scl_rise && ack_ph_q && in_read && sda_s_q && !start_seen && !stop_seen
      |=> state_q == qdt_pkg::ST_IGNORE)
    else $error("read continued after master no-acknowledge");

  a_short_write: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    (stop_seen || start_seen) && !pend_q |=> $stable({in_codes, dac_code, modes}))
    else $error("unfinished write changed channel state");

  a_hold_keeps: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    s_write_end and cw[qdt_pkg::HOLD_BIT] and cw[qdt_pkg::CLEAR_BIT] |=> $stable(dac_code))
    else $error("held write changed output registers");

  a_clear_zero: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    s_write_end and !cw[qdt_pkg::CLEAR_BIT] |=> in_codes == '0 && dac_code == '0)
    else $error("clear write did not zero registers");

  a_stop_release: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    stop_seen |=> !sda_oe && state_q == qdt_pkg::ST_IDLE)
    else $error("data line still driven after stop");

endmodule // qdt_twi

/* verif/qdt_bus_master.sv */
// Two-wire bus master model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda_in.
`timescale 1ns/1ps
module qdt_bus_master (
  // Clock
  input  wire logic mclk,
  // Bus
  input  wire logic sda_in,
  output logic      scl = 1'b1,
  output logic      sda_low = 1'b0
);
  // Low for 5 cycles with data moving 4 after the fall, high for 3: one 400 ns bit.
  task automatic bit_io(input logic lo, output logic s);
    @(posedge mclk) scl <= 1'b0;
    repeat (4) @(posedge mclk);
    sda_low <= lo;
    @(posedge mclk) scl <= 1'b1;
    repeat (2) @(posedge mclk);
    s = sda_in;
  endtask

  // Start and repeated start are cond(0,1), stop is cond(1,0); the clock then stands high.
  task automatic cond(input logic a, input logic b);
    @(posedge mclk) scl <= 1'b0;
    repeat (4) @(posedge mclk);
    sda_low <= a;
    @(posedge mclk) scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sda_low <= b;
    repeat (8) @(posedge mclk);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(~b[i], s);
    bit_io(1'b0, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, s);
      b[i] = s;
    end
    bit_io(mack, s);
  endtask
endmodule // qdt_bus_master

/* verif/tb.sv */
// Self-checking bench for the quad converter two-wire control block.
// Assumes a pull-up on the data wire; the master model and the device pull it low.
`timescale 1ns/1ps
module tb;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin = 1'b0;
  wire         scl;
  wire         m_low;
  logic        sda_out;
  logic        sda_oe;
  logic [47:0] dac_code;
  logic [3:0]  pd_hi, pd_lo, amp_en, t1k, t100k;
  wire         sda_w = (sda_oe ? sda_out : 1'b1) & ~m_low;
  logic [11:0] mi[4], mo[4];
  logic [1:0]  mm[4];
  logic [3:0]  dirty, mp;
  logic [67:0] eq[$], rq[$], e, g;
  int          kq[$];
  int          k, num_errors = 0, checked = 0, cyc = 0, seed = 32'h09DF;

  qdt_twi #(.RES(12)) DUT (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(pin), .dac_code(dac_code),
    .powerdown_sel_hi(pd_hi), .powerdown_sel_lo(pd_lo), .amp_en(amp_en),
    .term_1k_en(t1k), .term_100k_en(t100k));
  qdt_bus_master m (.mclk(mclk), .sda_in(sda_w), .scl(scl), .sda_low(m_low));

  initial forever #25 mclk = ~mclk;

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic report(input string nm, input logic [67:0] x, input logic [67:0] y);
    checked++;
    if (y !== x) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic cmp_ack(input logic x, input logic y);
    report("ack", 68'(x), 68'(y));
  endtask
  task automatic cmp_byte(input logic [7:0] x, input logic [7:0] y);
    report("read byte", 68'(x), 68'(y));
  endtask
  task automatic cmp_state(input logic [67:0] x, input logic [67:0] y);
    report("channel state", x, y);
  endtask
  always @(posedge mclk) begin
    while (rq.size() > 0) begin
      k = kq.pop_front();
      e = eq.pop_front();
      g = rq.pop_front();
      if (k == 0) cmp_ack(e[0], g[0]);
      else if (k == 1) cmp_byte(e[7:0], g[7:0]);
      else cmp_state(e, g);
    end
  end
  task automatic note(input int kk, input logic [67:0] x);
    kq.push_back(kk);
    eq.push_back(x);
  endtask
  function automatic logic [67:0] exp_state();
    logic [67:0] v;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      v[20+i*12 +: 12] = mo[i];
      v[16+i] = mm[i][1];
      v[12+i] = mm[i][0];
      v[8+i] = (mm[i] == 2'h0);
      v[4+i] = (mm[i] == 2'h1);
      v[i] = (mm[i] == 2'h2);
    end
    return v;
  endfunction
  task automatic snap();
    repeat (4) @(posedge mclk);
    note(2, exp_state());
    rq.push_back({dac_code, pd_hi, pd_lo, amp_en, t1k, t100k});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ************************************************************
  // Stimulus and reference model
  // ************************************************************
  function automatic logic [11:0] rnd();
    return 12'($random(seed));
  endfunction
  task automatic commit(input logic [3:0] p, input logic [15:0] w);
    for (int i = 0; i < 4; i++) begin
      if (!w[13]) begin
        mi[i] = '0;
        mo[i] = '0;
        dirty[i] = 1'b0;
      end else if (p[i]) begin
        mi[i] = w[11:0];
        dirty[i] = 1'b1;
      end
      if (p[i]) mm[i] = w[15:14];
    end
    for (int i = 0; i < 4; i++) begin
      if (w[13] && !w[12] && dirty[i]) begin
        mo[i] = mi[i];
        dirty[i] = 1'b0;
      end
    end
  endtask
  task automatic xbyte(input logic [7:0] b);
    logic a;
    m.put_byte(b, a);
    note(0, 1);
    rq.push_back(68'(a));
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] p, input logic [15:0] w, input int nb);
    logic a;
    logic ok;
    ok = (adr == {6'h06, pin});
    m.cond(1'b0, 1'b1);
    m.put_byte({adr, 1'b0}, a);
    note(0, 68'(ok));
    rq.push_back(68'(a));
    if (ok) begin
      xbyte(p);
      mp = p[3:0];
      for (int j = 0; j < nb; j++) xbyte(j ? w[7:0] : w[15:8]);
    end
    m.cond(1'b1, 1'b0);
    if (ok && nb == 2) commit(p[3:0], w);
    snap();
  endtask
  task automatic rd(input logic set, input logic [7:0] p, input int nb);
    logic [7:0] b;
    logic [15:0] x;
    int c;
    m.cond(1'b0, 1'b1);
    if (set) begin
      xbyte({6'h06, pin, 1'b0});
      xbyte(p);
      mp = p[3:0];
      m.cond(1'b0, 1'b1);
    end
    xbyte({6'h06, pin, 1'b1});
    c = 0;
    for (int i = 0; i < 4; i++) if (mp[i]) c = i;
    x = ($countones(mp) == 1) ? {mm[c], 2'h2, mi[c]} : 16'h2000;
    for (int n = 0; n < nb; n++) begin
      m.get_byte(n < nb - 1, b);
      note(1, n[0] ? x[7:0] : x[15:8]);
      rq.push_back(68'(b));
    end
    m.cond(1'b1, 1'b0);
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      mi[i] = '0;
      mo[i] = '0;
      mm[i] = '0;
    end
    dirty = '0;
    mp = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    snap();
    $display("test reset done");
    for (int i = 0; i < 3; i++) wr({6'h06, pin}, 8'h01 << i, {4'h3, rnd()}, 2);
    wr({6'h06, pin}, 8'h08, {4'h2, rnd()}, 2);
    wr({6'h06, pin}, 8'h01, {4'h3, rnd()}, 2);
    wr({6'h06, pin}, 8'h02, {4'h2, rnd()}, 2);
    $display("test update done");
    for (int md = 0; md < 4; md++) wr({6'h06, pin}, 8'h0F, {md[1:0], 2'h3, rnd()}, 2);
    wr({6'h06, pin}, 8'h06, {4'h2, rnd()}, 2);
    $display("test modes done");
    rd(1'b1, 8'h04, 6);
    rd(1'b0, 8'h00, 2);
    rd(1'b1, 8'h05, 2);
    $display("test readback done");
    wr({6'h06, pin}, 8'h01, {4'h2, rnd()}, 1);
    wr({6'h06, pin}, 8'h01, {4'h2, rnd()}, 0);
    wr({6'h06, ~pin}, 8'h01, {4'h2, rnd()}, 2);
    @(posedge mclk) pin <= 1'b1;
    repeat (8) @(posedge mclk);
    wr({6'h06, pin}, 8'h01, {4'h2, rnd()}, 2);
    wr({6'h06, pin}, 8'h02, {4'h1, rnd()}, 2);
    $display("test address and clear done");
    end_of_test();
  end
endmodule // tb
